// ### daq_adc_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
module daq_adc_control_regs
	import dacr_pkg::*;
#(
	parameter logic        HIGH_RES    = 1'b1,
	parameter logic [5:0]  BASE_ADDR   = 6'h22
)
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	input  wire logic [9:0]  io_addr_i,
	input  wire logic        io_rd_i,
	input  wire logic        io_wr_i,
	input  wire logic [15:0] io_wdata_i,
	input  wire logic        diff_mode_i,
	input  wire logic        ext_trig_i,
	input  wire logic        pacer_i,
	input  wire logic        dma_tc_i,
	input  wire logic        dma_ack_i,
	input  wire logic [15:0] conv_data_i,
	output logic      [15:0] io_rdata_o,
	output logic             io_sel_o,
	output logic             irq_o,
	output logic             dma_req_o,
	output logic      [1:0]  gain_o,
	output logic      [3:0]  mux_channel_o,
	output logic             conv_start_o
);
	logic [15:0] result_q, result_d;
	logic [15:0] rdata_d;
	logic        sel_d;
	logic        buffer_enable_bit_q, buffer_enable_bit_d;
	logic [1:0]  gain_q, gain_d;
	logic [3:0]  channel_select_field_q, channel_select_field_d;
	logic [1:0]  irq_src_q, irq_src_d;
	logic [3:0]  mode_q, mode_d;
	logic [3:0]  chan_q, chan_d;
	logic        irq_q, irq_d;
	logic        dreq_q, dreq_d;
	logic        start_q, start_d;
	logic        trig_prev_q, trig_prev_d;
	logic        ext_prev_q, ext_prev_d;
	logic        pacer_prev_q, pacer_prev_d;
	logic        half_prev_q, half_prev_d;
	logic        hit, rd_hit, wr_hit;
	logic [3:0]  off;
	logic        trig_lvl, trig_rise, irq_ev, sw_trig;
	logic        conv_busy, conv_done;
	logic        ff_full, ff_half, ff_empty, ff_pop;
	logic [15:0] ff_data;
	logic [15:0] sample;
	logic        auto_scan_on, dma_transfer_on;
	logic        external_trigger_select, internal_trigger_kind;
	logic [3:0]  stop_chan;

	function automatic logic [3:0] dacr_chan_limit(input logic [3:0] c,
		input logic diff);
		dacr_chan_limit = diff ? {1'b0, c[2:0]} : c;
	endfunction

	assign hit = io_addr_i[9:4] == BASE_ADDR;
	assign off = io_addr_i[3:0];
	assign rd_hit = hit && io_rd_i;
	assign wr_hit = hit && io_wr_i;
	assign auto_scan_on = mode_q[DACR_MODE_SCAN];
	assign dma_transfer_on = mode_q[DACR_MODE_DMA];
	assign external_trigger_select = mode_q[DACR_MODE_EXT];
	assign internal_trigger_kind = mode_q[DACR_MODE_PACER];
	assign stop_chan = dacr_chan_limit(channel_select_field_q, diff_mode_i);
	assign sw_trig = rd_hit && off == DACR_OFF_CHANNEL
		&& !external_trigger_select && !internal_trigger_kind;
	assign ff_pop = (rd_hit && off == DACR_OFF_BUFFER && buffer_enable_bit_q)
		|| (dma_ack_i && dma_transfer_on);
	assign sample = HIGH_RES ? conv_data_i
		: {conv_data_i[15:4], 4'h0};

	dacr_conv u_conv (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.start_i   (start_q),
		.busy_o    (conv_busy),
		.done_o    (conv_done)
	);

	dacr_fifo u_fifo (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.ce_i        (ce_i),
		.clear_i     (!buffer_enable_bit_q),
		.push_i      (conv_done && buffer_enable_bit_q),
		.push_data_i (sample),
		.pop_i       (ff_pop),
		.pop_data_o  (ff_data),
		.full_o      (ff_full),
		.half_o      (ff_half),
		.empty_o     (ff_empty)
	);

	always_comb begin
		buffer_enable_bit_d = buffer_enable_bit_q;
		gain_d = gain_q;
		channel_select_field_d = channel_select_field_q;
		irq_src_d = irq_src_q;
		mode_d = mode_q;
		if (wr_hit) begin
			unique case (off)
				DACR_OFF_STATUS: buffer_enable_bit_d = io_wdata_i[0];
				DACR_OFF_GAIN: gain_d = io_wdata_i[1:0];
				DACR_OFF_CHANNEL: channel_select_field_d = io_wdata_i[3:0];
				DACR_OFF_IRQSRC: irq_src_d = io_wdata_i[1:0];
				DACR_OFF_MODE: mode_d = io_wdata_i[3:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		trig_lvl = external_trigger_select ? ext_trig_i
			: internal_trigger_kind ? pacer_i : sw_trig;
		trig_prev_d = trig_lvl;
		trig_rise = trig_lvl && !trig_prev_q;
		start_d = trig_rise && !conv_busy && !start_q;
		ext_prev_d = ext_trig_i;
		pacer_prev_d = pacer_i;
		half_prev_d = ff_half;
		chan_d = chan_q;
		if (wr_hit && off == DACR_OFF_MODE && !auto_scan_on
			&& io_wdata_i[DACR_MODE_SCAN]) begin
			chan_d = 4'h0;
		end else if (wr_hit && off == DACR_OFF_CHANNEL && !auto_scan_on) begin
			chan_d = dacr_chan_limit(io_wdata_i[3:0], diff_mode_i);
		end else if (!auto_scan_on) begin
			chan_d = stop_chan;
		end else if (conv_done) begin
			chan_d = (chan_q >= stop_chan) ? 4'h0 : chan_q + 4'h1;
		end
		result_d = conv_done ? sample : result_q;
	end

	always_comb begin
		if (dma_transfer_on) begin
			irq_ev = dma_tc_i;
		end else begin
			unique case (irq_src_q)
				DACR_IRQ_EOC: irq_ev = conv_done;
				DACR_IRQ_EXT: irq_ev = ext_trig_i && !ext_prev_q;
				DACR_IRQ_PACER: irq_ev = pacer_i && !pacer_prev_q;
				DACR_IRQ_HALF: irq_ev = ff_half && !half_prev_q;
			endcase
		end
		irq_d = irq_q;
		if (rd_hit && off == DACR_OFF_GAIN) begin
			irq_d = 1'b0;
		end
		if (irq_ev) begin
			irq_d = 1'b1;
		end
		dreq_d = dma_transfer_on && !ff_empty && !dma_ack_i;
	end

	always_comb begin
		rdata_d = 16'h0000;
		sel_d = hit && (io_rd_i || io_wr_i);
		if (rd_hit) begin
			unique case (off)
				DACR_OFF_RESULT: rdata_d = result_q;
				DACR_OFF_BUFFER: rdata_d = buffer_enable_bit_q
					? ff_data : 16'h0000;
				DACR_OFF_STATUS: rdata_d = {8'h00, !conv_busy, ff_full,
					ff_half, ff_empty, chan_q[3] | diff_mode_i,
					chan_q[2:0]};
				DACR_OFF_IRQSRC: rdata_d = {14'h0000, irq_src_q};
				DACR_OFF_MODE: rdata_d = {12'h000, mode_q};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			result_q <= '0;
			io_rdata_o <= '0;
			io_sel_o <= 1'b0;
			buffer_enable_bit_q <= 1'b0;
			gain_q <= '0;
			channel_select_field_q <= '0;
			irq_src_q <= '0;
			mode_q <= '0;
			chan_q <= '0;
			irq_q <= 1'b0;
			dreq_q <= 1'b0;
			start_q <= 1'b0;
			trig_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
			pacer_prev_q <= 1'b0;
			half_prev_q <= 1'b0;
			irq_o <= 1'b0;
			dma_req_o <= 1'b0;
			gain_o <= '0;
			mux_channel_o <= '0;
			conv_start_o <= 1'b0;
		end else if (ce_i) begin
			result_q <= result_d;
			io_rdata_o <= rdata_d;
			io_sel_o <= sel_d;
			buffer_enable_bit_q <= buffer_enable_bit_d;
			gain_q <= gain_d;
			channel_select_field_q <= channel_select_field_d;
			irq_src_q <= irq_src_d;
			mode_q <= mode_d;
			chan_q <= chan_d;
			irq_q <= irq_d;
			dreq_q <= dreq_d;
			start_q <= start_d;
			trig_prev_q <= trig_prev_d;
			ext_prev_q <= ext_prev_d;
			pacer_prev_q <= pacer_prev_d;
			half_prev_q <= half_prev_d;
			irq_o <= irq_d;
			dma_req_o <= dreq_d;
			gain_o <= gain_d;
			mux_channel_o <= chan_d;
			conv_start_o <= start_d;
		end
	end
endmodule
`default_nettype wire

// ### dacr_pkg.sv
`default_nettype none
package dacr_pkg;
	localparam logic [3:0] DACR_OFF_RESULT  = 4'h4;
	localparam logic [3:0] DACR_OFF_BUFFER  = 4'h6;
	localparam logic [3:0] DACR_OFF_STATUS  = 4'h8;
	localparam logic [3:0] DACR_OFF_GAIN    = 4'h9;
	localparam logic [3:0] DACR_OFF_CHANNEL = 4'ha;
	localparam logic [3:0] DACR_OFF_IRQSRC  = 4'hb;
	localparam logic [3:0] DACR_OFF_MODE    = 4'hc;
	localparam int DACR_MODE_DMA   = 3;
	localparam int DACR_MODE_EXT   = 2;
	localparam int DACR_MODE_PACER = 1;
	localparam int DACR_MODE_SCAN  = 0;
	localparam int DACR_ST_IDLE  = 7;
	localparam int DACR_ST_FULL  = 6;
	localparam int DACR_ST_HALF  = 5;
	localparam int DACR_ST_EMPTY = 4;
	localparam logic [1:0] DACR_IRQ_EOC   = 2'h0;
	localparam logic [1:0] DACR_IRQ_EXT   = 2'h1;
	localparam logic [1:0] DACR_IRQ_PACER = 2'h2;
	localparam logic [1:0] DACR_IRQ_HALF  = 2'h3;
	localparam int DACR_FIFO_DEPTH = 1024;
	localparam int DACR_FIFO_AW    = 10;
	localparam int DACR_CONV_NS    = 10000;
	localparam int DACR_CLK_NS     = 10;
	localparam logic [15:0] DACR_CONV_CYC =
		16'((DACR_CONV_NS + DACR_CLK_NS - 1) / DACR_CLK_NS);
endpackage
`default_nettype wire

// ### dacr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dacr_fifo
	import dacr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	input  wire logic        clear_i,
	input  wire logic        push_i,
	input  wire logic [15:0] push_data_i,
	input  wire logic        pop_i,
	output logic      [15:0] pop_data_o,
	output logic             full_o,
	output logic             half_o,
	output logic             empty_o
);
	logic [15:0]            mem_q [DACR_FIFO_DEPTH];
	logic [DACR_FIFO_AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [DACR_FIFO_AW:0]   cnt_q, cnt_d;
	logic                    do_push, do_pop;

	always_comb begin
		do_push = push_i && !full_o;
		do_pop = pop_i && !empty_o;
		wr_d = wr_q + DACR_FIFO_AW'(do_push);
		rd_d = rd_q + DACR_FIFO_AW'(do_pop);
		cnt_d = cnt_q + (DACR_FIFO_AW+1)'(do_push)
			- (DACR_FIFO_AW+1)'(do_pop);
		if (clear_i) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && do_push && !clear_i) begin
			mem_q[wr_q] <= push_data_i;
		end
	end

	assign pop_data_o = mem_q[rd_q];
	assign full_o = cnt_q == (DACR_FIFO_AW+1)'(DACR_FIFO_DEPTH);
	assign half_o = cnt_q >= (DACR_FIFO_AW+1)'(DACR_FIFO_DEPTH / 2);
	assign empty_o = cnt_q == '0;
endmodule
`default_nettype wire

// ### dacr_conv.sv
`timescale 1ns/100ps
`default_nettype none
module dacr_conv
	import dacr_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	logic [15:0] cnt_q, cnt_d;
	logic        busy_d, done_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_o;
		done_d = 1'b0;
		if (busy_o) begin
			if (cnt_q == 16'h0001) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			cnt_d = cnt_q - 16'h0001;
		end else if (start_i) begin
			busy_d = 1'b1;
			cnt_d = DACR_CONV_CYC;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
			busy_o <= busy_d;
			done_o <= done_d;
		end
	end
endmodule
`default_nettype wire

// ### dacr_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dacr_properties
	import dacr_pkg::*;
#(
	parameter logic [5:0] BASE_ADDR = 6'h22
)
(
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        ce_i,
	input wire logic [9:0]  io_addr_i,
	input wire logic        io_rd_i,
	input wire logic        io_wr_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic        ext_trig_i,
	input wire logic        pacer_i,
	input wire logic        dma_tc_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic        io_sel_o,
	input wire logic        irq_o,
	input wire logic        dma_req_o,
	input wire logic [1:0]  gain_o,
	input wire logic        conv_start_o
);
	logic        hit;
	logic [3:0]  mode_q;
	logic [10:0] busy_q;
	assign hit = ce_i && (io_rd_i || io_wr_i) && io_addr_i[9:4] == BASE_ADDR;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_q <= 4'h0;
			busy_q <= 11'h0;
		end else if (ce_i) begin
			if (hit && io_wr_i && io_addr_i[3:0] == DACR_OFF_MODE)
				mode_q <= io_wdata_i[3:0];
			if (conv_start_o)
				busy_q <= 11'h3f0;
			else if (busy_q != 11'h0)
				busy_q <= busy_q - 11'h1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_sel_hit: assert property (hit |=> io_sel_o)
		else $error("window access not selected");
	chk_sel_miss: assert property (ce_i && !hit |=> !io_sel_o)
		else $error("select without access");
	chk_rdata_zero: assert property
		(ce_i && !(hit && io_rd_i) |=> io_rdata_o == 16'h0)
		else $error("read data not zero");
	chk_gain_load: assert property
		(hit && io_wr_i && io_addr_i[3:0] == DACR_OFF_GAIN
		|=> gain_o == $past(io_wdata_i[1:0])) else $error("gain wrong");
	chk_start_pulse: assert property
		(conv_start_o |=> !conv_start_o [*8]) else $error("start too long");
	chk_sw_trig: assert property
		(hit && io_rd_i && io_addr_i[3:0] == DACR_OFF_CHANNEL
		&& mode_q[2:1] == 2'h0 && busy_q == 11'h0 && !conv_start_o
		|-> ##[1:2] conv_start_o)
		else $error("software trigger lost");
	chk_ext_trig: assert property
		(ce_i && $rose(ext_trig_i) && mode_q[2] && busy_q == 11'h0
		&& !conv_start_o
		|-> ##[1:3] conv_start_o) else $error("external trigger lost");
	chk_irq_clear: assert property
		(hit && io_rd_i && io_addr_i[3:0] == DACR_OFF_GAIN && busy_q == 11'h0
		&& !ext_trig_i && !pacer_i && !dma_tc_i |=> !irq_o)
		else $error("interrupt not cleared");
	chk_dma_gate: assert property (ce_i && !mode_q[3] |=> !dma_req_o)
		else $error("dma request while polling");
	chk_irq_dma: assert property
		($rose(irq_o) && mode_q[3] && $past(mode_q[3])
		|-> $past(dma_tc_i) || $past(dma_tc_i, 2))
		else $error("dma interrupt without terminal count");
	cover property (conv_start_o);
	cover property ($rose(irq_o) && mode_q[3]);
	cover property (dma_req_o && hit);
endmodule
bind daq_adc_control_regs dacr_properties #(.BASE_ADDR(BASE_ADDR)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
	.io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
	.io_wdata_i(io_wdata_i), .ext_trig_i(ext_trig_i), .pacer_i(pacer_i),
	.dma_tc_i(dma_tc_i), .io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o),
	.irq_o(irq_o), .dma_req_o(dma_req_o), .gain_o(gain_o),
	.conv_start_o(conv_start_o));
`default_nettype wire

// ### dacr_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
module dacr_dma_model #(
	parameter int ACK_DLY = 40,
	parameter int NWORDS  = 1
)
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic dma_req_i,
	output var logic  dma_ack_o = 1'b0,
	output var logic  dma_tc_o = 1'b0
);
	int wait_n;
	int words;
	always @(negedge clk_i) begin
		dma_ack_o <= 1'b0;
		dma_tc_o <= 1'b0;
		if (sys_rst_i) begin
			wait_n = 0;
			words = 0;
		end else if (dma_req_i && !dma_ack_o) begin
			if (wait_n < ACK_DLY) begin
				wait_n++;
			end else begin
				wait_n = 0;
				words++;
				dma_ack_o <= 1'b1;
				dma_tc_o <= (words == NWORDS);
			end
		end
	end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
	import dacr_pkg::*;
;
	localparam logic [5:0] BASE = 6'h22;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, io_rd_i = 1'b0;
	logic io_wr_i = 1'b0, diff_mode_i = 1'b0, ext_trig_i = 1'b0;
	logic pacer_i = 1'b0, dma_tc_i, dma_ack_i, io_sel_o, irq_o, dma_req_o;
	logic [9:0]  io_addr_i = 10'h0;
	logic [15:0] io_wdata_i = 16'h0, conv_data_i = 16'h0, io_rdata_o;
	logic [1:0]  gain_o;
	logic [3:0]  mux_channel_o;
	logic        conv_start_o;
	logic [5:0]  blk = BASE;
	int          miscompares = 0, n_compared = 0, cyc = 0;
	daq_adc_control_regs #(.HIGH_RES(1'b1), .BASE_ADDR(BASE)) u_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
		.io_wdata_i(io_wdata_i), .diff_mode_i(diff_mode_i),
		.ext_trig_i(ext_trig_i), .pacer_i(pacer_i), .dma_tc_i(dma_tc_i),
		.dma_ack_i(dma_ack_i), .conv_data_i(conv_data_i),
		.io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o), .irq_o(irq_o),
		.dma_req_o(dma_req_o), .gain_o(gain_o),
		.mux_channel_o(mux_channel_o), .conv_start_o(conv_start_o));
	dacr_dma_model u_dma (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.dma_req_i(dma_req_o), .dma_ack_o(dma_ack_i), .dma_tc_o(dma_tc_i));
	always #5 clk_i = ~clk_i;
	task automatic wr(input logic [3:0] o, input logic [15:0] d);
		@(negedge clk_i);
		io_addr_i = {blk, o};
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge clk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic ck(input string nm, input logic [3:0] o,
		input logic [15:0] e);
		@(negedge clk_i);
		io_addr_i = {blk, o};
		io_rd_i = 1'b1;
		@(negedge clk_i);
		io_rd_i = 1'b0;
		`CMP(nm, e, io_rdata_o)
	endtask
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		wr(DACR_OFF_IRQSRC, 16'h00ff);
		ck("irq source", DACR_OFF_IRQSRC, 16'h0003);
		wr(DACR_OFF_MODE, 16'h00f2);
		ck("mode", DACR_OFF_MODE, 16'h0002);
		wr(DACR_OFF_MODE, 16'h0000);
		wr(DACR_OFF_IRQSRC, 16'h0000);
		for (int g = 0; g < 4; g++) begin
			wr(DACR_OFF_GAIN, 16'h00fc | 16'(g));
			`CMP("gain", 2'(g), gain_o)
		end
		blk = BASE + 6'h1;
		ck("outside", DACR_OFF_MODE, 16'h0000);
		blk = BASE;
		$display("register test done");
		wr(DACR_OFF_STATUS, 16'h0001);
		wr(DACR_OFF_CHANNEL, 16'h0005);
		conv_data_i = 16'hbeef;
		ck("soft trigger", DACR_OFF_CHANNEL, 16'h0000);
		repeat (1010) @(negedge clk_i);
		ck("result", DACR_OFF_RESULT, 16'hbeef);
		`CMP("irq eoc", 1'b1, irq_o)
		ck("status", DACR_OFF_STATUS, 16'h0085);
		ck("clear", DACR_OFF_GAIN, 16'h0000);
		`CMP("irq cleared", 1'b0, irq_o)
		ck("buffer", DACR_OFF_BUFFER, 16'hbeef);
		diff_mode_i = 1'b1;
		ck("status diff", DACR_OFF_STATUS, 16'h009d);
		diff_mode_i = 1'b0;
		wr(DACR_OFF_STATUS, 16'h0000);
		conv_data_i = 16'h1234;
		ck("soft trigger", DACR_OFF_CHANNEL, 16'h0000);
		repeat (1010) @(negedge clk_i);
		ck("refresh", DACR_OFF_RESULT, 16'h1234);
		ck("buffer off", DACR_OFF_BUFFER, 16'h0000);
		$display("software conversion test done");
		wr(DACR_OFF_IRQSRC, 16'h0001);
		wr(DACR_OFF_CHANNEL, 16'h0000);
		wr(DACR_OFF_MODE, 16'h0005);
		wr(DACR_OFF_CHANNEL, 16'h0002);
		ck("clear", DACR_OFF_GAIN, 16'h0000);
		for (int i = 1; i <= 3; i++) begin
			@(negedge clk_i);
			ext_trig_i = 1'b1;
			repeat (4) @(negedge clk_i);
			ext_trig_i = 1'b0;
			`CMP("irq external", 1'b1, irq_o)
			ck("clear", DACR_OFF_GAIN, 16'h0000);
			repeat (1010) @(negedge clk_i);
			`CMP("scan channel", 4'(i % 3), mux_channel_o)
		end
		$display("scan test done");
		wr(DACR_OFF_IRQSRC, 16'h0002);
		wr(DACR_OFF_MODE, 16'h0002);
		conv_data_i = 16'h5a5a;
		@(negedge clk_i);
		pacer_i = 1'b1;
		@(negedge clk_i);
		pacer_i = 1'b0;
		`CMP("irq pacer", 1'b1, irq_o)
		repeat (1010) @(negedge clk_i);
		ck("pacer result", DACR_OFF_RESULT, 16'h5a5a);
		ck("clear", DACR_OFF_GAIN, 16'h0000);
		`CMP("irq pacer cleared", 1'b0, irq_o)
		$display("pacer test done");
		wr(DACR_OFF_IRQSRC, 16'h0000);
		wr(DACR_OFF_STATUS, 16'h0001);
		wr(DACR_OFF_MODE, 16'h0008);
		ck("soft trigger", DACR_OFF_CHANNEL, 16'h0000);
		repeat (1010) @(negedge clk_i);
		`CMP("irq before tc", 1'b0, irq_o)
		repeat (60) @(negedge clk_i);
		`CMP("irq on tc", 1'b1, irq_o)
		ck("status dma", DACR_OFF_STATUS, 16'h0092);
		$display("dma test done");
		close_out();
	end
endmodule
`default_nettype wire
